// ### led_driver_serial_command_decoder.sv
// top of the serial command decoder: strobe-counted commands acted on in the clock domain
// assumes shift_clock is free of clock, rst_n is synchronous to clock
`timescale 1ns/100ps
module led_driver_serial_command_decoder (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic shift_clock,
    input wire logic frame_strobe,
    input wire logic serial_in,
    output logic serial_out,
    output logic [15:0] sink_outputs,
    output logic gs_source_shift
);
    typedef struct packed {
        logic [2:0] cmd_sync;
        logic unlocked;
        logic [4:0] latches;
        logic [3:0] wptr;
        logic wbank;
        logic resume_live;
        led_cmd_pkg::out_mode_t mode;
        logic [15:0] config_word;
        logic cfg_toggle;
        logic [15:0] sink;
        logic gs_source;
        logic [1:0][15:0][15:0] frame;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic cmd_event;
    logic [15:0] lit;

    link_xfer_if lx ();

    serial_front_end front (
        .shift_clock(shift_clock),
        .rst_n(rst_n),
        .frame_strobe(frame_strobe),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .lx(lx)
    );

    function automatic logic cmd_hit(input logic ev, input logic [4:0] count, input logic [4:0] code);
        return ev && (count == code);
    endfunction : cmd_hit

    // toggle crossing; fields are stable long before the toggle arrives
    assign cmd_event = st.cmd_sync[1] ^ st.cmd_sync[2];
    assign lx.cfg_toggle = st.cfg_toggle;
    assign lx.cfg_word = st.config_word;
    assign sink_outputs = st.sink;
    assign gs_source_shift = st.gs_source;

    logic hit_latch;
    logic hit_vsync;
    logic hit_cfg_write;
    logic hit_soft_reset;
    logic hit_all_on;
    logic hit_all_off;
    logic hit_unlock;

    assign hit_latch = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_LATCH);
    assign hit_vsync = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_VSYNC);
    assign hit_cfg_write = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_CFG_WRITE);
    assign hit_soft_reset = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_SOFT_RESET);
    assign hit_all_on = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_ALL_ON);
    assign hit_all_off = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_ALL_OFF);
    assign hit_unlock = cmd_hit(cmd_event, lx.cmd_count, led_cmd_pkg::CMD_UNLOCK);

    always_comb begin
        lit = '0;
        // displayed bank is the one not being written
        for (int i = 0; i < led_cmd_pkg::CHANNELS; i++) begin
            lit[i] = |st.frame[~st.wbank][i];
        end
    end

    always_comb begin
        next_st = st;
        next_st.cmd_sync = {st.cmd_sync[1:0], lx.cmd_toggle};
        next_st.gs_source = st.config_word[led_cmd_pkg::CFG_GS_SOURCE_BIT];

        // any command, read and unknown counts included, consumes the unlock
        if (cmd_event) begin
            next_st.unlocked = 1'b0;
        end
        if (hit_unlock) begin
            next_st.unlocked = 1'b1;
        end

        if (hit_latch) begin
            next_st.frame[st.wbank][led_cmd_pkg::LAST_CHANNEL - st.wptr] = lx.cmd_word;
            next_st.wptr = 4'(st.wptr + 4'h1);
            if (st.latches != led_cmd_pkg::LATCHES_BEFORE_VSYNC) begin
                next_st.latches = 5'(st.latches + 5'h01);
            end
            if (st.mode == led_cmd_pkg::MODE_ON || st.mode == led_cmd_pkg::MODE_OFF) begin
                next_st.mode = st.resume_live ? led_cmd_pkg::MODE_LIVE : led_cmd_pkg::MODE_BLANK;
            end
        end

        if (hit_vsync && st.latches == led_cmd_pkg::LATCHES_BEFORE_VSYNC) begin
            // a forced state survives the swap; it is ended by a latch or a soft reset
            next_st.wbank = ~st.wbank;
            next_st.wptr = led_cmd_pkg::WPTR_RESET;
            next_st.resume_live = 1'b1;
            if (st.mode == led_cmd_pkg::MODE_BLANK) begin
                next_st.mode = led_cmd_pkg::MODE_LIVE;
            end
        end

        if (hit_cfg_write && st.unlocked) begin
            next_st.config_word = lx.cmd_word;
            next_st.cfg_toggle = ~st.cfg_toggle;
        end

        if (hit_soft_reset) begin
            // stored grey-scale data and latch count survive, so the next update shows them
            next_st.wptr = led_cmd_pkg::WPTR_RESET;
            next_st.resume_live = 1'b0;
            next_st.mode = led_cmd_pkg::MODE_BLANK;
        end

        if (hit_all_on && st.unlocked) begin
            next_st.mode = led_cmd_pkg::MODE_ON;
        end
        if (hit_all_off && st.unlocked) begin
            next_st.mode = led_cmd_pkg::MODE_OFF;
        end

        unique case (st.mode)
            led_cmd_pkg::MODE_BLANK: next_st.sink = 16'h0000;
            led_cmd_pkg::MODE_LIVE: next_st.sink = lit;
            led_cmd_pkg::MODE_ON: next_st.sink = 16'hffff;
            led_cmd_pkg::MODE_OFF: next_st.sink = 16'h0000;
        endcase

        if (!rst_n) begin
            next_st = '0;
            next_st.mode = led_cmd_pkg::MODE_BLANK;
            next_st.config_word = led_cmd_pkg::CONFIG_RESET;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    property p_latch_count;
        @(posedge clock) disable iff (!rst_n)
        (hit_latch && st.latches < led_cmd_pkg::LATCHES_BEFORE_VSYNC) |=> st.latches == 5'($past(st.latches) + 5'h01);
    endproperty
    a_latch_count: assert property (p_latch_count) else $error("latch count did not advance");

    property p_latch_store;
        @(posedge clock) disable iff (!rst_n)
        (hit_latch && st.wptr == led_cmd_pkg::WPTR_RESET) |=>
            (st.frame[st.wbank][led_cmd_pkg::LAST_CHANNEL] == $past(lx.cmd_word)) && (st.wptr == 4'h1);
    endproperty
    a_latch_store: assert property (p_latch_store) else $error("latched word not stored");

    property p_vsync_apply;
        @(posedge clock) disable iff (!rst_n)
        (hit_vsync && st.latches == led_cmd_pkg::LATCHES_BEFORE_VSYNC) |=>
            (st.wbank != $past(st.wbank)) && (st.wptr == led_cmd_pkg::WPTR_RESET) && st.resume_live;
    endproperty
    a_vsync_apply: assert property (p_vsync_apply) else $error("frame update not applied");

    property p_vsync_ignore;
        @(posedge clock) disable iff (!rst_n)
        (hit_vsync && st.latches < led_cmd_pkg::LATCHES_BEFORE_VSYNC) |=> $stable(st.wbank) ##1 $stable(st.wbank);
    endproperty
    a_vsync_ignore: assert property (p_vsync_ignore) else $error("early frame update accepted");

    property p_cfg_write;
        @(posedge clock) disable iff (!rst_n)
        (hit_cfg_write && st.unlocked) |=> (st.config_word == $past(lx.cmd_word)) && !st.unlocked;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("unlocked config write lost");

    property p_gate;
        @(posedge clock) disable iff (!rst_n)
        ((hit_cfg_write || hit_all_on || hit_all_off) && !st.unlocked) |=> $stable(st.config_word) && $stable(st.mode);
    endproperty
    a_gate: assert property (p_gate) else $error("locked command took effect");

    property p_unlock;
        @(posedge clock) disable iff (!rst_n)
        hit_unlock |=> st.unlocked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock not armed");

    property p_all_on;
        @(posedge clock) disable iff (!rst_n)
        (hit_all_on && st.unlocked) |=> ##1 (sink_outputs == 16'hffff);
    endproperty
    a_all_on: assert property (p_all_on) else $error("outputs not forced on");

    property p_all_off;
        @(posedge clock) disable iff (!rst_n)
        (hit_all_off && st.unlocked) |=> ##1 (sink_outputs == 16'h0000);
    endproperty
    a_all_off: assert property (p_all_off) else $error("outputs not forced off");

    property p_latch_ends_force;
        @(posedge clock) disable iff (!rst_n)
        (hit_latch && (st.mode == led_cmd_pkg::MODE_ON || st.mode == led_cmd_pkg::MODE_OFF)) |=>
            (st.mode == led_cmd_pkg::MODE_LIVE || st.mode == led_cmd_pkg::MODE_BLANK);
    endproperty
    a_latch_ends_force: assert property (p_latch_ends_force) else $error("latch left output forced");

    property p_soft_reset;
        @(posedge clock) disable iff (!rst_n)
        hit_soft_reset |=> $stable(st.config_word) ##1 (sink_outputs == 16'h0000);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset misbehaved");

    property p_config_reset;
        @(posedge clock) disable iff (!rst_n)
        !$past(rst_n) |-> (st.config_word == led_cmd_pkg::CONFIG_RESET) && (st.mode == led_cmd_pkg::MODE_BLANK);
    endproperty
    a_config_reset: assert property (p_config_reset) else $error("config reset value wrong");

    c_vsync_taken: cover property (@(posedge clock) disable iff (!rst_n)
        hit_vsync && st.latches == led_cmd_pkg::LATCHES_BEFORE_VSYNC);
    c_cfg_written: cover property (@(posedge clock) disable iff (!rst_n) hit_cfg_write && st.unlocked);
    c_force_on: cover property (@(posedge clock) disable iff (!rst_n) hit_all_on && st.unlocked);
    c_force_cleared: cover property (@(posedge clock) disable iff (!rst_n) hit_latch && st.mode == led_cmd_pkg::MODE_ON);

endmodule : led_driver_serial_command_decoder

// ### led_cmd_pkg.sv
// constants and types shared by the serial command decoder files
// assumes nothing of its surroundings; imported by no one, used by scoped names
package led_cmd_pkg;

    localparam int WORD_BITS = 16;
    localparam int CHANNELS = 16;
    localparam int COUNT_BITS = 5;

    // number of shift_clock rising edges seen while frame_strobe is high
    localparam logic [4:0] CMD_LATCH = 5'h01;
    localparam logic [4:0] CMD_VSYNC = 5'h03;
    localparam logic [4:0] CMD_CFG_WRITE = 5'h04;
    localparam logic [4:0] CMD_CFG_READ = 5'h05;
    localparam logic [4:0] CMD_SOFT_RESET = 5'h0a;
    localparam logic [4:0] CMD_ALL_ON = 5'h0b;
    localparam logic [4:0] CMD_ALL_OFF = 5'h0c;
    localparam logic [4:0] CMD_UNLOCK = 5'h0e;
    localparam logic [4:0] COUNT_MAX = 5'h1f;
    localparam logic [4:0] COUNT_RESET = 5'h00;

    localparam logic [4:0] LATCHES_BEFORE_VSYNC = 5'h10;
    localparam logic [3:0] LAST_CHANNEL = 4'hf;
    localparam logic [3:0] WPTR_RESET = 4'h0;

    localparam logic [15:0] CONFIG_RESET = 16'h032b;
    localparam int CFG_GS_SOURCE_BIT = 13;

    typedef enum logic [1:0] {
        MODE_BLANK = 2'b00,
        MODE_LIVE = 2'b01,
        MODE_ON = 2'b11,
        MODE_OFF = 2'b10
    } out_mode_t;

endpackage : led_cmd_pkg

// ### link_xfer_if.sv
// carrier between the shift_clock front end and the system-clock core
// assumes: command fields stay stable from one toggle until the next toggle
`timescale 1ns/100ps
interface link_xfer_if;
    logic cmd_toggle;
    logic [4:0] cmd_count;
    logic [15:0] cmd_word;
    logic cfg_toggle;
    logic [15:0] cfg_word;

    modport link (output cmd_toggle, output cmd_count, output cmd_word, input cfg_toggle, input cfg_word);
    modport core (input cmd_toggle, input cmd_count, input cmd_word, output cfg_toggle, output cfg_word);
endinterface : link_xfer_if

// ### serial_front_end.sv
// shift register, strobe edge counter and serial output, all on shift_clock
// assumes frame_strobe and serial_in are launched on shift_clock by the host
`timescale 1ns/100ps
module serial_front_end (
    input wire logic shift_clock,
    input wire logic rst_n,
    input wire logic frame_strobe,
    input wire logic serial_in,
    output logic serial_out,
    link_xfer_if.link lx
);
    typedef struct packed {
        logic [2:0] rsync;
        logic [2:0] cfg_sync;
        logic [4:0] count;
        logic [15:0] shreg;
        logic [15:0] shadow;
        logic cmd_toggle;
        logic [4:0] cmd_count;
        logic [15:0] cmd_word;
    } link_state_t;

    link_state_t st;
    link_state_t next_st;
    logic link_reset;

    assign link_reset = !(st.rsync[1] && st.rsync[2]);
    assign serial_out = st.shreg[15];
    assign lx.cmd_toggle = st.cmd_toggle;
    assign lx.cmd_count = st.cmd_count;
    assign lx.cmd_word = st.cmd_word;

    always_comb begin
        next_st = st;
        next_st.rsync = {st.rsync[1:0], rst_n};
        next_st.cfg_sync = {st.cfg_sync[1:0], lx.cfg_toggle};
        if (st.cfg_sync[1] != st.cfg_sync[2]) begin
            next_st.shadow = lx.cfg_word;
        end
        next_st.shreg = {st.shreg[14:0], serial_in};
        if (frame_strobe) begin
            if (st.count != led_cmd_pkg::COUNT_MAX) begin
                next_st.count = 5'(st.count + 5'h01);
            end
        end else if (st.count != led_cmd_pkg::COUNT_RESET) begin
            // word is taken before this edge's shift: the last 16 bits before the strobe fell
            next_st.count = led_cmd_pkg::COUNT_RESET;
            next_st.cmd_toggle = ~st.cmd_toggle;
            next_st.cmd_count = st.count;
            next_st.cmd_word = st.shreg;
            if (st.count == led_cmd_pkg::CMD_CFG_READ) begin
                next_st.shreg = st.shadow;
            end
        end
        if (link_reset) begin
            next_st = '0;
            next_st.rsync = {st.rsync[1:0], rst_n};
            next_st.shadow = led_cmd_pkg::CONFIG_RESET;
        end
    end

    always_ff @(posedge shift_clock) begin
        st <= next_st;
    end

    property p_shift_chain;
        @(posedge shift_clock) disable iff (link_reset)
        (frame_strobe || st.count != led_cmd_pkg::CMD_CFG_READ) |=> serial_out == $past(st.shreg[14]);
    endproperty
    a_shift_chain: assert property (p_shift_chain) else $error("serial chain did not advance");

    property p_read_out;
        @(posedge shift_clock) disable iff (link_reset)
        (!frame_strobe && st.count == led_cmd_pkg::CMD_CFG_READ) |=>
            (serial_out == $past(st.shadow[15])) ##1 (serial_out == $past(st.shadow[14], 2));
    endproperty
    a_read_out: assert property (p_read_out) else $error("config read not shifted msb first");

    property p_cmd_event;
        @(posedge shift_clock) disable iff (link_reset)
        (!frame_strobe && st.count != led_cmd_pkg::COUNT_RESET) |=>
            (lx.cmd_toggle != $past(lx.cmd_toggle)) && (lx.cmd_count == $past(st.count));
    endproperty
    a_cmd_event: assert property (p_cmd_event) else $error("command not issued at strobe fall");

endmodule : serial_front_end

// ### host_model.sv
// host controller model: drives shift_clock, frame_strobe and serial_in for whole commands
// assumes the bench calls its tasks one at a time; shift_clock stands still between calls
`timescale 1ns/100ps
module host_model (
    output logic shift_clock,
    output logic frame_strobe,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        shift_clock = 1'b0;
        frame_strobe = 1'b0;
        serial_in = 1'b0;
    end

    // one 80 ns link period; data and strobe change while the clock is low
    task automatic edge_once(input logic d, input logic s);
        serial_in = d;
        frame_strobe = s;
        #20 shift_clock = 1'b1;
        #40 shift_clock = 1'b0;
        #20;
    endtask : edge_once

    // released data line shows the inverse of its last value, not a held copy
    task automatic idle(input int n);
        repeat (n) edge_once(~serial_in, 1'b0);
    endtask : idle

    task automatic send(input logic [15:0] w, input int n, input int trail, output logic [15:0] rd);
        for (int i = 0; i < 16; i++) begin
            edge_once(w[15 - i], 1'(i >= 16 - n));
        end
        edge_once(~serial_in, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rd[15 - i] = serial_out;
            if (i < trail - 1) begin
                edge_once(~serial_in, 1'b0);
            end
        end
    endtask : send
endmodule : host_model

// ### tb.sv
// self-checking bench for the serial command decoder, host model on the link side
// assumes the decoder acts on a command well within 12 clocks after its last link edge
`timescale 1ns/100ps
module tb;
    logic clock, rst_n, serial_out, shift_clock, frame_strobe, serial_in, gs_source_shift;
    logic [15:0] sink_outputs;
    logic [15:0] bank [2][16];
    logic [15:0] cfg;
    logic [1:0] mode;
    bit wsel, unlocked, shown;
    int wptr, nlatch, seed, fail_count, comparisons;
    int cycles = 0;
    logic [4:0] corner [16] = '{5'h0b, 5'h0e, 5'h0b, 5'h01, 5'h0e, 5'h01, 5'h0c, 5'h0e, 5'h0c,
        5'h01, 5'h0a, 5'h05, 5'h03, 5'h04, 5'h0e, 5'h04};
    logic [4:0] pool [12] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0a, 5'h0b, 5'h0c,
        5'h0d, 5'h0e, 5'h10};

    led_driver_serial_command_decoder uut (.clock(clock), .rst_n(rst_n), .shift_clock(shift_clock),
        .frame_strobe(frame_strobe), .serial_in(serial_in), .serial_out(serial_out),
        .sink_outputs(sink_outputs), .gs_source_shift(gs_source_shift));
    host_model host (.shift_clock(shift_clock), .frame_strobe(frame_strobe), .serial_in(serial_in),
        .serial_out(serial_out));

    initial clock = 1'b0;
    // grey-scale timing rides on clock, far above a fifth of the link rate
    always #5 clock = ~clock;

    // generous ceiling: roughly two and a half times the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // mode: 0 blank, 1 live, 2 forced on, 3 forced off
    function automatic logic [15:0] exp_sink();
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 16; i++) v[i] = |bank[~wsel][i];
        if (mode == 2'h2) v = 16'hffff;
        else if (mode != 2'h1) v = 16'h0000;
        return v;
    endfunction : exp_sink

    task automatic run(input logic [4:0] cmd, input logic [15:0] w, input int trail);
        logic [15:0] rd;
        bit gate_ok;
        if (cmd == led_cmd_pkg::CMD_CFG_READ) trail = 16;
        host.send(w, int'(cmd), trail, rd);
        gate_ok = unlocked;
        unlocked = (cmd == led_cmd_pkg::CMD_UNLOCK);
        case (cmd)
            led_cmd_pkg::CMD_LATCH: begin
                bank[wsel][15 - wptr] = w;
                wptr = (wptr + 1) % 16;
                nlatch++;
                if (mode[1]) mode = shown ? 2'h1 : 2'h0;
            end
            led_cmd_pkg::CMD_VSYNC: if (nlatch >= 16) begin
                wsel = ~wsel;
                wptr = 0;
                shown = 1'b1;
                if (!mode[1]) mode = 2'h1;
            end
            led_cmd_pkg::CMD_CFG_WRITE: if (gate_ok) cfg = w;
            led_cmd_pkg::CMD_SOFT_RESET: begin
                mode = 2'h0;
                wptr = 0;
                shown = 1'b0;
            end
            led_cmd_pkg::CMD_ALL_ON: if (gate_ok) mode = 2'h2;
            led_cmd_pkg::CMD_ALL_OFF: if (gate_ok) mode = 2'h3;
            default: ;
        endcase
        repeat (12) @(negedge clock);
        check(sink_outputs, exp_sink());
        check({15'h0000, gs_source_shift}, {15'h0000, cfg[led_cmd_pkg::CFG_GS_SOURCE_BIT]});
        if (cmd == led_cmd_pkg::CMD_CFG_READ) check(rd, cfg);
    endtask : run

    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    initial begin
        seed = 81855;
        rst_n = 1'b0;
        mode = 2'h0;
        wsel = 1'b0;
        unlocked = 1'b0;
        shown = 1'b0;
        wptr = 0;
        nlatch = 0;
        fail_count = 0;
        comparisons = 0;
        cfg = led_cmd_pkg::CONFIG_RESET;
        // the link side resets through a synchroniser, so shift_clock runs during reset
        #3;
        fork
            host.idle(6);
            repeat (48) @(negedge clock);
        join
        @(negedge clock);
        rst_n = 1'b1;
        host.idle(6);
        run(led_cmd_pkg::CMD_CFG_READ, 16'h0000, 16);
        for (int k = 0; k < 15; k++) run(led_cmd_pkg::CMD_LATCH, (k == 3) ? 16'h0000 : 16'($random(seed)), 5);
        run(led_cmd_pkg::CMD_VSYNC, 16'($random(seed)), 5);
        run(led_cmd_pkg::CMD_LATCH, 16'($random(seed)), 5);
        run(led_cmd_pkg::CMD_VSYNC, 16'($random(seed)), 1);
        for (int k = 0; k < 16; k++) run(led_cmd_pkg::CMD_LATCH, (k == 0) ? 16'h0000 : 16'($random(seed)), 1);
        run(led_cmd_pkg::CMD_VSYNC, 16'($random(seed)), 5);
        // unlock followed by its gated command with only the strobe-fall edge and that command's leading low edges between them
        foreach (corner[i]) run(corner[i], 16'($random(seed)) | 16'h2000, (corner[i] == 5'h0e) ? 1 : 5);
        repeat (40) run(pool[$unsigned($random(seed)) % 12], 16'($random(seed)), 5);
        finish_test();
    end
endmodule : tb
